// ---- inc/ser_consts.svh ----
// constants of the status event reporting block: presets, queue depth, listing sizes
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

// preset values of masks and transition filters
`define SER_MASK_PRESET   16'h0000
`define SER_RISE_PRESET   15'h7FFF
`define SER_FALL_PRESET   15'h0000

// error queue
`define SER_QUEUE_DEPTH   5'h1E
`define SER_QUEUE_AW      5

// command listing block: payload length and count of its length digits
`define SER_LIST_LEN      7'h45
`define SER_LIST_NDIG     4'h2

// ascii characters used in responses
`define SER_CH_PLUS       8'h2B
`define SER_CH_MINUS      8'h2D
`define SER_CH_COMMA      8'h2C
`define SER_CH_QUOTE      8'h22
`define SER_CH_HASH       8'h23
`define SER_CH_ZERO       8'h30

`endif

// ---- inc/ser_pkg.sv ----
// types of the status event reporting block: command codes and response states
package ser_pkg;

  typedef enum logic [3:0] {
    SER_OP_COND_Q  = 4'h0,
    SER_OP_EVENT_Q = 4'h1,
    SER_OP_MASK_W  = 4'h2,
    SER_OP_MASK_Q  = 4'h3,
    SER_OP_RISE_W  = 4'h4,
    SER_OP_RISE_Q  = 4'h5,
    SER_OP_FALL_W  = 4'h6,
    SER_OP_FALL_Q  = 4'h7,
    SER_OP_PRESET  = 4'h8,
    SER_OP_CLEAR   = 4'h9,
    SER_OP_ERR_Q   = 4'hA,
    SER_OP_LIST_Q  = 4'hB
  } ser_op_e;

  typedef enum logic [3:0] {
    SER_ST_IDLE  = 4'h0,
    SER_ST_FETCH = 4'h1,
    SER_ST_SIGN  = 4'h2,
    SER_ST_HUND  = 4'h3,
    SER_ST_TENS  = 4'h4,
    SER_ST_ONES  = 4'h5,
    SER_ST_COMMA = 4'h6,
    SER_ST_OPENQ = 4'h7,
    SER_ST_TEXT  = 4'h8,
    SER_ST_CLOSQ = 4'h9,
    SER_ST_LHASH = 4'hA,
    SER_ST_LNDIG = 4'hB,
    SER_ST_LDIG1 = 4'hC,
    SER_ST_LDIG2 = 4'hD,
    SER_ST_LBODY = 4'hE
  } ser_state_e;

endpackage

// ---- logic/ser_err_mem.sv ----
// storage of the error queue: one entry per word, registered read data
`timescale 1ns/100ps
`include "ser_consts.svh"

module ser_err_mem (
  input  wire logic                     clk_sys,
  input  wire logic                     wr_en,
  input  wire logic [`SER_QUEUE_AW-1:0] wr_addr,
  input  wire logic [11:0]              wr_data,
  input  wire logic [`SER_QUEUE_AW-1:0] rd_addr,
  output logic      [11:0]              rd_data
);

  logic [11:0] mem [0:(1<<`SER_QUEUE_AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- logic/ser_status_core.sv ----
// status event reporting: condition filters, event latches, summary bits, error queue, listing
`timescale 1ns/100ps
`include "ser_consts.svh"

module ser_status_core (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire ser_pkg::ser_op_e  cmd_op,
  input  wire logic              cmd_grp,
  input  wire logic [15:0]       cmd_data,
  output logic                   rsp_valid,
  output logic      [15:0]       rsp_value,
  output logic                   txt_valid,
  output logic      [7:0]        txt_byte,
  output logic                   txt_last,
  input  wire logic              txt_ready,
  input  wire logic [14:0]       cond_oper,
  input  wire logic [14:0]       cond_ques,
  input  wire logic              err_push,
  input  wire logic [9:0]        err_code,
  input  wire logic [1:0]        err_text,
  output logic                   stb_sum_ques,
  output logic                   stb_sum_oper,
  output logic      [4:0]        err_count
);
  import ser_pkg::*;

  // ----------------------------------------------------------------
  // response texts
  // ----------------------------------------------------------------
  localparam logic [127:0] TXT_NONE  = "No errors";
  localparam logic [127:0] TXT_UNDEF = "Undefined header";
  localparam logic [127:0] TXT_OVER  = "Queue overflow";
  localparam logic [127:0] TXT_DEV   = "Device error";

  localparam logic [8*`SER_LIST_LEN-1:0] LIST_TEXT = {
    ":STAT:PRES/nquery/\n",
    ":SYST:ERR?/qonly/\n",
    ":SYST:LIST?/qonly/\n",
    "*CLS/nquery/\n"
  };

  function automatic logic [4:0] text_len(input logic [1:0] id);
    logic [4:0] n;
    n = 5'h09;
    unique case (id)
      2'h0: n = 5'h09;
      2'h1: n = 5'h10;
      2'h2: n = 5'h0E;
      2'h3: n = 5'h0C;
    endcase
    return n;
  endfunction

  // texts are right-justified in their vectors, so index from the low end
  function automatic logic [7:0] text_char(input logic [1:0] id, input logic [6:0] pos);
    logic [127:0] s;
    int           base;
    s = TXT_NONE;
    unique case (id)
      2'h0: s = TXT_NONE;
      2'h1: s = TXT_UNDEF;
      2'h2: s = TXT_OVER;
      2'h3: s = TXT_DEV;
    endcase
    base = (int'(text_len(id)) - 1 - int'(pos)) * 8;
    return s[base +: 8];
  endfunction

  function automatic logic [7:0] list_char(input logic [6:0] pos);
    int base;
    base = (int'(`SER_LIST_LEN) - 1 - int'(pos)) * 8;
    return LIST_TEXT[base +: 8];
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  ser_state_e  st;
  ser_state_e  next_st;
  logic        take;
  logic        is_preset;
  logic        is_clear;
  logic [14:0] cond_now  [2];
  logic [14:0] cond_prev [2];
  logic [14:0] ev        [2];
  logic [14:0] next_ev   [2];
  logic [15:0] mask      [2];
  logic [14:0] rise      [2];
  logic [14:0] fall      [2];

  assign cmd_ready   = (st == SER_ST_IDLE);
  assign take        = cmd_valid && cmd_ready;
  assign is_preset   = take && (cmd_op == SER_OP_PRESET);
  assign is_clear    = take && (cmd_op == SER_OP_CLEAR);
  assign cond_now[0] = cond_oper;
  assign cond_now[1] = cond_ques;

  // ----------------------------------------------------------------
  // condition edges and event latches
  // ----------------------------------------------------------------
  // group 0 is operation, group 1 questionable
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      cond_prev[g] <= cond_now[g];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      logic [14:0] set_bits;
      logic        clr;
      set_bits = (~cond_prev[g] & cond_now[g] & rise[g])
               | (cond_prev[g] & ~cond_now[g] & fall[g]);
      clr = is_clear
          || (take && (cmd_op == SER_OP_EVENT_Q) && (cmd_grp == g[0]));
      next_ev[g] = (clr ? 15'h0000 : ev[g]) | set_bits;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      if (sys_rst) begin
        ev[g] <= 15'h0000;
      end else begin
        ev[g] <= next_ev[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // masks and transition filters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      if (sys_rst || is_preset) begin
        mask[g] <= `SER_MASK_PRESET;
        rise[g] <= `SER_RISE_PRESET;
        fall[g] <= `SER_FALL_PRESET;
      end else if (take && (cmd_grp == g[0])) begin
        if (cmd_op == SER_OP_MASK_W) begin
          mask[g] <= cmd_data;
        end
        // the top bit is dropped, any 16-bit value is taken
        if (cmd_op == SER_OP_RISE_W) begin
          rise[g] <= cmd_data[14:0];
        end
        if (cmd_op == SER_OP_FALL_W) begin
          fall[g] <= cmd_data[14:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status byte summaries
  // ----------------------------------------------------------------
  logic [15:0] next_mask [2];

  // summaries follow a mask written in the same cycle, so a preset drops them at once
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      next_mask[g] = mask[g];
      if (is_preset) begin
        next_mask[g] = `SER_MASK_PRESET;
      end else if (take && (cmd_grp == g[0]) && (cmd_op == SER_OP_MASK_W)) begin
        next_mask[g] = cmd_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stb_sum_oper <= 1'b0;
      stb_sum_ques <= 1'b0;
    end else begin
      stb_sum_oper <= |(next_ev[0] & next_mask[0][14:0]);
      stb_sum_ques <= |(next_ev[1] & next_mask[1][14:0]);
    end
  end

  // ----------------------------------------------------------------
  // numeric query answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_value <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (take) begin
        unique case (cmd_op)
          SER_OP_COND_Q: begin
            rsp_valid <= 1'b1;
            rsp_value <= {1'b0, cond_now[cmd_grp]};
          end
          SER_OP_EVENT_Q: begin
            rsp_valid <= 1'b1;
            rsp_value <= {1'b0, ev[cmd_grp]};
          end
          SER_OP_MASK_Q: begin
            rsp_valid <= 1'b1;
            rsp_value <= mask[cmd_grp];
          end
          SER_OP_RISE_Q: begin
            rsp_valid <= 1'b1;
            rsp_value <= {1'b0, rise[cmd_grp]};
          end
          SER_OP_FALL_Q: begin
            rsp_valid <= 1'b1;
            rsp_value <= {1'b0, fall[cmd_grp]};
          end
          default: begin
            rsp_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  logic [4:0]  q_head;
  logic [4:0]  q_tail;
  logic        q_pop;
  logic        q_push;
  logic [4:0]  wr_addr;
  logic [11:0] mem_rd;
  logic        empty_flag;

  // when full a new error is dropped unless a pop or a clear frees room that cycle
  assign q_pop   = take && (cmd_op == SER_OP_ERR_Q) && (err_count != 5'h00);
  assign q_push  = err_push && (is_clear || q_pop || (err_count != `SER_QUEUE_DEPTH));
  assign wr_addr = is_clear ? 5'h00 : q_tail;

  function automatic logic [4:0] q_inc(input logic [4:0] p);
    return (p == `SER_QUEUE_DEPTH - 5'h01) ? 5'h00 : p + 5'h01;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q_head    <= 5'h00;
      q_tail    <= 5'h00;
      err_count <= 5'h00;
    end else if (is_clear) begin
      // an error arriving during the clear is kept
      q_head    <= 5'h00;
      q_tail    <= q_push ? 5'h01 : 5'h00;
      err_count <= q_push ? 5'h01 : 5'h00;
    end else begin
      if (q_pop) begin
        q_head <= q_inc(q_head);
      end
      if (q_push) begin
        q_tail <= q_inc(q_tail);
      end
      err_count <= err_count + (q_push ? 5'h01 : 5'h00) - (q_pop ? 5'h01 : 5'h00);
    end
  end

  ser_err_mem u_mem (
    .clk_sys (clk_sys),
    .wr_en   (q_push),
    .wr_addr (wr_addr),
    .wr_data ({err_text, err_code}),
    .rd_addr (q_head),
    .rd_data (mem_rd)
  );

  // ----------------------------------------------------------------
  // text answer sequencer
  // ----------------------------------------------------------------
  logic [6:0]  idx;
  logic [6:0]  next_idx;
  logic [9:0]  ent_code;
  logic [1:0]  ent_text;
  logic [9:0]  eff_code;
  logic [1:0]  eff_text;
  logic [9:0]  mag;
  logic [3:0]  dig_h;
  logic [3:0]  dig_t;
  logic [3:0]  dig_o;
  logic        adv;
  logic [7:0]  next_byte;

  // the entry is read straight from memory in the fetch cycle
  assign eff_code = (st == SER_ST_FETCH) ? (empty_flag ? 10'h000 : mem_rd[9:0]) : ent_code;
  assign eff_text = (st == SER_ST_FETCH) ? (empty_flag ? 2'h0 : mem_rd[11:10]) : ent_text;
  assign mag      = eff_code[9] ? 10'(-eff_code) : eff_code;
  assign dig_h    = 4'(mag / 10'h064);
  assign dig_t    = 4'((mag / 10'h00A) % 10'h00A);
  assign dig_o    = 4'(mag % 10'h00A);
  assign adv      = txt_valid && txt_ready;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      empty_flag <= 1'b1;
      ent_code   <= 10'h000;
      ent_text   <= 2'h0;
    end else begin
      if (take && (cmd_op == SER_OP_ERR_Q)) begin
        empty_flag <= (err_count == 5'h00);
      end
      if (st == SER_ST_FETCH) begin
        ent_code <= eff_code;
        ent_text <= eff_text;
      end
    end
  end

  always_comb begin
    next_st  = st;
    next_idx = idx;
    unique case (st)
      SER_ST_IDLE: begin
        if (take && (cmd_op == SER_OP_ERR_Q)) begin
          next_st = SER_ST_FETCH;
        end else if (take && (cmd_op == SER_OP_LIST_Q)) begin
          next_st = SER_ST_LHASH;
        end
      end
      SER_ST_FETCH: next_st = SER_ST_SIGN;
      SER_ST_SIGN: begin
        if (adv) begin
          // leading zeros of the code are suppressed
          next_st = (dig_h != 4'h0) ? SER_ST_HUND : ((dig_t != 4'h0) ? SER_ST_TENS : SER_ST_ONES);
        end
      end
      SER_ST_HUND:  if (adv) next_st = SER_ST_TENS;
      SER_ST_TENS:  if (adv) next_st = SER_ST_ONES;
      SER_ST_ONES:  if (adv) next_st = SER_ST_COMMA;
      SER_ST_COMMA: if (adv) next_st = SER_ST_OPENQ;
      SER_ST_OPENQ: begin
        if (adv) begin
          next_st  = SER_ST_TEXT;
          next_idx = 7'h00;
        end
      end
      SER_ST_TEXT: begin
        if (adv) begin
          if (idx == 7'({2'h0, text_len(ent_text)} - 7'h01)) begin
            next_st = SER_ST_CLOSQ;
          end else begin
            next_idx = idx + 7'h01;
          end
        end
      end
      SER_ST_CLOSQ: if (adv) next_st = SER_ST_IDLE;
      SER_ST_LHASH: if (adv) next_st = SER_ST_LNDIG;
      SER_ST_LNDIG: if (adv) next_st = SER_ST_LDIG1;
      SER_ST_LDIG1: if (adv) next_st = SER_ST_LDIG2;
      SER_ST_LDIG2: begin
        if (adv) begin
          next_st  = SER_ST_LBODY;
          next_idx = 7'h00;
        end
      end
      SER_ST_LBODY: begin
        if (adv) begin
          if (idx == `SER_LIST_LEN - 7'h01) begin
            next_st = SER_ST_IDLE;
          end else begin
            next_idx = idx + 7'h01;
          end
        end
      end
      default: next_st = SER_ST_IDLE;
    endcase
  end

  // byte for the state being entered, so the data output is a register
  always_comb begin
    next_byte = 8'h00;
    unique case (next_st)
      SER_ST_SIGN:  next_byte = eff_code[9] ? `SER_CH_MINUS : `SER_CH_PLUS;
      SER_ST_HUND:  next_byte = `SER_CH_ZERO + {4'h0, dig_h};
      SER_ST_TENS:  next_byte = `SER_CH_ZERO + {4'h0, dig_t};
      SER_ST_ONES:  next_byte = `SER_CH_ZERO + {4'h0, dig_o};
      SER_ST_COMMA: next_byte = `SER_CH_COMMA;
      SER_ST_OPENQ: next_byte = `SER_CH_QUOTE;
      SER_ST_TEXT:  next_byte = text_char(ent_text, next_idx);
      SER_ST_CLOSQ: next_byte = `SER_CH_QUOTE;
      SER_ST_LHASH: next_byte = `SER_CH_HASH;
      SER_ST_LNDIG: next_byte = `SER_CH_ZERO + {4'h0, `SER_LIST_NDIG};
      SER_ST_LDIG1: next_byte = `SER_CH_ZERO + {1'b0, 7'(`SER_LIST_LEN / 7'h0A)};
      SER_ST_LDIG2: next_byte = `SER_CH_ZERO + {1'b0, 7'(`SER_LIST_LEN % 7'h0A)};
      SER_ST_LBODY: next_byte = list_char(next_idx);
      default:      next_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st        <= SER_ST_IDLE;
      idx       <= 7'h00;
      txt_valid <= 1'b0;
      txt_byte  <= 8'h00;
      txt_last  <= 1'b0;
    end else begin
      st        <= next_st;
      idx       <= next_idx;
      txt_valid <= (next_st != SER_ST_IDLE) && (next_st != SER_ST_FETCH);
      txt_byte  <= next_byte;
      txt_last  <= (next_st == SER_ST_CLOSQ)
                || ((next_st == SER_ST_LBODY) && (next_idx == `SER_LIST_LEN - 7'h01));
    end
  end

endmodule

// ---- dv/ser_status_core_checker.sv ----
// concurrent checks on the ports of the status event reporting core
`timescale 1ns/100ps

module ser_status_core_checker (
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire ser_pkg::ser_op_e cmd_op,
  input wire logic             cmd_grp,
  input wire logic [15:0]      cmd_data,
  input wire logic             rsp_valid,
  input wire logic [15:0]      rsp_value,
  input wire logic             txt_valid,
  input wire logic [7:0]       txt_byte,
  input wire logic             txt_ready,
  input wire logic [14:0]      cond_ques,
  input wire logic             err_push,
  input wire logic             stb_sum_ques,
  input wire logic             stb_sum_oper,
  input wire logic [4:0]       err_count
);
  import ser_pkg::*;
  // -------------------------------------------------------------
  // helpers and assertions
  // -------------------------------------------------------------
  logic tk;
  logic tk_num;
  logic tk_low;
  assign tk = cmd_valid && cmd_ready;
  assign tk_num = tk && (cmd_op inside {SER_OP_COND_Q, SER_OP_EVENT_Q, SER_OP_MASK_Q, SER_OP_RISE_Q, SER_OP_FALL_Q});
  assign tk_low = tk && (cmd_op inside {SER_OP_EVENT_Q, SER_OP_RISE_Q, SER_OP_FALL_Q});
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_num_answer: assert property (tk_num |=> rsp_valid)
    else $error("numeric query gave no answer");
  a_no_stray: assert property (rsp_valid |-> $past(tk_num))
    else $error("answer without a query");
  a_top_bit: assert property (rsp_valid && $past(tk_low) |-> !rsp_value[15])
    else $error("bit 15 set in filter or event answer");
  a_cond_value: assert property (tk && cmd_op == SER_OP_COND_Q && cmd_grp |=> rsp_value == {1'b0, $past(cond_ques)})
    else $error("condition answer differs from inputs");
  a_list_hash: assert property (tk && cmd_op == SER_OP_LIST_Q |=> txt_valid && txt_byte == 8'h23 && !cmd_ready)
    else $error("listing does not open with hash");
  a_err_fetch: assert property (tk && cmd_op == SER_OP_ERR_Q |=> !txt_valid && !cmd_ready ##1 txt_valid)
    else $error("error answer timing wrong");
  a_text_hold: assert property (txt_valid && !txt_ready |=> txt_valid && $stable(txt_byte))
    else $error("text byte dropped while stalled");
  a_mask_zero: assert property (tk && cmd_op == SER_OP_MASK_W && cmd_grp && cmd_data == 16'h0000 |=> !stb_sum_ques)
    else $error("summary stays with mask cleared");
  a_preset_sum: assert property (tk && cmd_op == SER_OP_PRESET |=> !stb_sum_ques && !stb_sum_oper)
    else $error("summary set after preset");
  a_preset_queue: assert property (tk && cmd_op == SER_OP_PRESET && !err_push |=> $stable(err_count))
    else $error("preset changed error queue");
  a_clear_queue: assert property (tk && cmd_op == SER_OP_CLEAR && !err_push |=> err_count == 5'h00)
    else $error("clear left errors queued");
  a_queue_limit: assert property (err_count <= 5'h1E)
    else $error("error count above depth");
  a_push_count: assert property (err_push && cmd_ready && !tk && err_count < 5'h1E |=> err_count == $past(err_count) + 5'h01)
    else $error("pushed error not counted");

  c_list: cover property (tk && cmd_op == SER_OP_LIST_Q);
  c_err: cover property (tk && cmd_op == SER_OP_ERR_Q);
  c_full: cover property (err_count == 5'h1E);
endmodule

bind ser_status_core ser_status_core_checker chk_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_grp(cmd_grp), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_value(rsp_value), .txt_valid(txt_valid), .txt_byte(txt_byte), .txt_ready(txt_ready),
  .cond_ques(cond_ques), .err_push(err_push), .stb_sum_ques(stb_sum_ques),
  .stb_sum_oper(stb_sum_oper), .err_count(err_count)
);

// ---- dv/ser_host_sink.sv ----
// host model: takes text answer bytes, stalling one cycle in four
`timescale 1ns/100ps

module ser_host_sink (
  input  wire logic       clk_sys,
  input  wire logic       txt_valid,
  input  wire logic [7:0] txt_byte,
  input  wire logic       txt_last,
  output logic            txt_ready
);
  logic [7:0] rx[$];
  logic       fin;
  logic [1:0] cnt;
  initial begin
    txt_ready = 1'b0;
    fin = 1'b0;
    cnt = 2'h0;
  end
  // stalls make the core hold each byte until it is taken
  always @(negedge clk_sys) begin
    cnt <= cnt + 2'h1;
    txt_ready <= (cnt != 2'h3);
  end
  always @(posedge clk_sys) begin
    if (txt_valid && txt_ready) begin
      rx.push_back(txt_byte);
      if (txt_last) fin <= 1'b1;
    end
  end
endmodule

// ---- dv/ser_status_core_tb_top.sv ----
// self-checking bench of the status event reporting core
`timescale 1ns/100ps

module ser_status_core_tb_top;
  import ser_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  logic        cmd_valid;
  logic        cmd_ready;
  ser_op_e     cmd_op;
  logic        cmd_grp;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic [15:0] rsp_value;
  logic        txt_valid;
  logic [7:0]  txt_byte;
  logic        txt_last;
  logic        txt_ready;
  logic [14:0] cond_oper;
  logic [14:0] cond_ques;
  logic        err_push;
  logic [9:0]  err_code;
  logic [1:0]  err_text;
  logic        stb_sum_ques;
  logic        stb_sum_oper;
  logic [4:0]  err_count;
  logic [15:0] rv;
  int          n_fail;
  int          cmp_count;
  int          cyc;

  ser_status_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_grp(cmd_grp), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_value(rsp_value),
    .txt_valid(txt_valid), .txt_byte(txt_byte), .txt_last(txt_last), .txt_ready(txt_ready),
    .cond_oper(cond_oper), .cond_ques(cond_ques), .err_push(err_push), .err_code(err_code),
    .err_text(err_text), .stb_sum_ques(stb_sum_ques), .stb_sum_oper(stb_sum_oper), .err_count(err_count));
  ser_host_sink host (.clk_sys(clk_sys), .txt_valid(txt_valid), .txt_byte(txt_byte), .txt_last(txt_last),
    .txt_ready(txt_ready));

  always #25 clk_sys = ~clk_sys;

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ready is sampled at the falling edge: it only moves at rising edges
  task automatic cmd(input ser_op_e op, input logic g, input logic [15:0] d);
    int i;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_grp = g;
    cmd_data = d;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i++;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    rv = rsp_value;
    // one idle cycle keeps the next call from raising valid in the same time step
    @(negedge clk_sys);
  endtask

  task automatic txq(input ser_op_e op, input string e);
    int i;
    host.rx.delete();
    host.fin = 1'b0;
    cmd(op, 1'b0, 16'h0000);
    i = 0;
    while (host.fin !== 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i++;
    end
    chk(16'(host.rx.size()), 16'(e.len()));
    for (i = 0; i < e.len() && i < host.rx.size(); i++) chk({8'h00, host.rx[i]}, {8'h00, e[i]});
  endtask

  task automatic chk_pre();
    for (int g = 0; g < 2; g++) begin
      cmd(SER_OP_MASK_Q, g[0], 16'h0000);
      chk(rv, 16'h0000);
      cmd(SER_OP_RISE_Q, g[0], 16'h0000);
      chk(rv, 16'h7FFF);
      cmd(SER_OP_FALL_Q, g[0], 16'h0000);
      chk(rv, 16'h0000);
    end
  endtask

  task automatic push(input logic [9:0] c, input logic [1:0] t);
    err_push = 1'b1;
    err_code = c;
    err_text = t;
    @(negedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = SER_OP_COND_Q;
    cmd_grp = 1'b0;
    cmd_data = 16'h0000;
    cond_oper = 15'h0010;
    cond_ques = 15'h0000;
    err_push = 1'b0;
    err_code = 10'h000;
    err_text = 2'h0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk_pre();
    cmd(SER_OP_COND_Q, 1'b0, 16'h0000);
    chk(rv, 16'h0010);
    cmd(SER_OP_MASK_W, 1'b1, 16'hFFFF);
    cmd(SER_OP_MASK_Q, 1'b1, 16'h0000);
    chk(rv, 16'hFFFF);
    cmd(SER_OP_FALL_W, 1'b1, 16'hFFFF);
    cmd(SER_OP_FALL_Q, 1'b1, 16'h0000);
    chk(rv, 16'h7FFF);
    cmd(SER_OP_MASK_W, 1'b1, 16'h0004);
    cond_ques = 15'h0004;
    repeat (2) @(negedge clk_sys);
    chk({15'h0000, stb_sum_ques}, 16'h0001);
    cond_ques = 15'h0000;
    repeat (2) @(negedge clk_sys);
    cmd(SER_OP_EVENT_Q, 1'b1, 16'h0000);
    chk(rv, 16'h0004);
    chk({15'h0000, stb_sum_ques}, 16'h0000);
    cmd(SER_OP_EVENT_Q, 1'b1, 16'h0000);
    chk(rv, 16'h0000);
    cmd(SER_OP_FALL_W, 1'b0, 16'h0010);
    cmd(SER_OP_MASK_W, 1'b0, 16'h0010);
    cond_oper = 15'h0000;
    repeat (2) @(negedge clk_sys);
    chk({15'h0000, stb_sum_oper}, 16'h0001);
    cond_oper = 15'h0010;
    cmd(SER_OP_PRESET, 1'b0, 16'h0000);
    chk({15'h0000, stb_sum_oper}, 16'h0000);
    chk_pre();
    cmd(SER_OP_EVENT_Q, 1'b0, 16'h0000);
    chk(rv, 16'h0010);
    cond_oper = 15'h0000;
    repeat (2) @(negedge clk_sys);
    cond_oper = 15'h0010;
    repeat (2) @(negedge clk_sys);
    cmd(SER_OP_CLEAR, 1'b0, 16'h0000);
    cmd(SER_OP_EVENT_Q, 1'b0, 16'h0000);
    chk(rv, 16'h0000);
    push(10'h38F, 2'h1);
    err_push = 1'b0;
    txq(SER_OP_ERR_Q, "-113,\"Undefined header\"");
    txq(SER_OP_ERR_Q, "+0,\"No errors\"");
    push(10'h007, 2'h3);
    repeat (30) push(10'h009, 2'h2);
    err_push = 1'b0;
    @(negedge clk_sys);
    chk({11'h000, err_count}, 16'h001E);
    txq(SER_OP_ERR_Q, "+7,\"Device error\"");
    cmd(SER_OP_PRESET, 1'b0, 16'h0000);
    chk({11'h000, err_count}, 16'h001D);
    cmd(SER_OP_CLEAR, 1'b0, 16'h0000);
    chk({11'h000, err_count}, 16'h0000);
    txq(SER_OP_LIST_Q, {"#269:STAT:PRES/nquery/\n:SYST:ERR?/qonly/\n", ":SYST:LIST?/qonly/\n*CLS/nquery/\n"});
    wrap_up();
  end
endmodule
